// *** src/brsq_pkg.sv ***
package brsq_pkg;

  // ---------------------------------------------------------------
  // Clock and time bases
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 125_000_000;
  localparam int unsigned TICK_US       = 100;
  localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned TICK_W        = 14;

  // Times in milliseconds, counted in 100 us ticks
  localparam logic [15:0] PRE_DLY_MS    = 16'h0096;
  localparam logic [15:0] CLOSE_DLY_MS  = 16'h03E8;
  localparam logic [15:0] STALL_MS      = 16'h00C8;
  localparam logic [15:0] HOLD_DLY_MS   = 16'h0032;
  localparam logic [15:0] TICKS_PER_MS  = 16'h000A;
  localparam logic [7:0]  STALL_PCT     = 8'h1E;
  localparam logic [23:0] PCT_FULL      = 24'h00_0064;
  localparam logic [15:0] BACKOFF_INC   = 16'h0004;
  localparam logic [15:0] DRAG_LIMIT    = 16'h0100;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] REG_CTRL       = 8'h00;
  localparam logic [7:0] REG_STATUS     = 8'h04;
  localparam logic [7:0] REG_PRE_DLY    = 8'h08;
  localparam logic [7:0] REG_CLOSE_DLY  = 8'h0C;
  localparam logic [7:0] REG_BACKOFF    = 8'h10;
  localparam logic [7:0] REG_STALL_PCT  = 8'h14;
  localparam logic [7:0] REG_STALL_MS   = 8'h18;
  localparam logic [7:0] REG_DRAG       = 8'h1C;
  localparam logic [7:0] REG_IRQ_STAT   = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK   = 8'h24;
  localparam logic [7:0] REG_BAUD       = 8'h28;
  localparam logic [7:0] REG_HOLD_DLY   = 8'h2C;

  // Control word bits
  localparam int CW_RUN_UP   = 0;
  localparam int CW_RUN_DN   = 1;
  localparam int CW_STOP     = 2;
  // Status word bits
  localparam int SW_MOVING   = 6;
  localparam int SW_DRAG     = 7;
  localparam int SW_BRAKE    = 8;
  localparam int SW_POS_ERR  = 10;

  // Interrupt event bits
  localparam int IRQ_W       = 4;
  localparam int EV_START    = 0;
  localparam int EV_END      = 1;
  localparam int EV_STALL    = 2;
  localparam int EV_DRAG     = 3;

  // Bit rate codes
  localparam logic [2:0] BAUD_50   = 3'h0;
  localparam logic [2:0] BAUD_125  = 3'h1;
  localparam logic [2:0] BAUD_250  = 3'h2;
  localparam logic [2:0] BAUD_500  = 3'h3;
  localparam logic [2:0] BAUD_1000 = 3'h4;

  typedef enum logic [1:0] {BRK_NONE, BRK_SNAP, BRK_HOLD} brsq_brake_t;

  typedef enum {
    ST_IDLE, ST_PRE, ST_BACKOFF, ST_RUN, ST_CLOSE
  } brsq_state_t;

  // Motion feedback from the drive core
  typedef struct packed {
    logic [15:0] target_speed;
    logic [15:0] actual_speed;
    logic [31:0] target_pos;
    logic [31:0] actual_pos;
    logic        run_done;
    logic        backoff_step;
  } brsq_motion_t;

  // Commands to the drive core
  typedef struct packed {
    logic        motor_en;
    logic        dir_up;
    logic        backoff;
    logic        brake_open;
  } brsq_drive_t;

endpackage

// *** src/brsq_top.sv ***
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
// Operation
// - Snap brake waits configurable delay before run
// - Snap brake backs off increments opposite direction
// - Snap brake closes after configurable end delay
// - New run during close delay skips release
// - Holding brake waits idle period before run
// - Holding brake releases when run finishes
// - Abort run when speed stays too low
// - Status bit 6 set while moving
// - Stall clears bit 6, sets bit 10
// - Switch selects 125, 250 or 500 kbaud
// - Bus setting adds 50 and 1000 kbaud
// - Flag drag error beyond configured limit
module brsq_top
  import brsq_pkg::*;
(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [31:0]  wb_dat_i,
  input  wire logic         wb_we_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  output logic              wb_err_o,
  input  wire brsq_brake_t  brake_kind_i,
  input  wire logic [1:0]   baud_switch_i,
  input  wire brsq_motion_t motion_i,
  output brsq_drive_t       drive_o,
  output logic [2:0]        baud_sel_o,
  output logic              irq_o
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] pre_dly;
    logic [15:0] close_dly;
    logic [15:0] hold_dly;
    logic [15:0] backoff;
    logic [7:0]  stall_pct;
    logic [15:0] stall_ms;
    logic [15:0] drag;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic        baud_bus;
    logic [2:0]  baud_code;
    logic [2:0]  sw_q1;
    logic [2:0]  sw_q2;
    logic [2:0]  sw_q3;
    brsq_state_t st;
    logic        dir_up;
    logic [TICK_W-1:0] pre_cnt;
    logic        tick;
    logic [19:0] tcnt;
    logic [15:0] bcnt;
    logic [19:0] scnt;
    logic        moving;
    logic        pos_err;
    logic        drag_err;
    logic        brake_open;
    logic [31:0] rdata;
    logic        ack;
    logic        err;
  } brsq_regs_t;

  brsq_regs_t r;
  brsq_regs_t next_r;

  logic        req;
  logic        wr;
  logic        cmd;
  logic        slow;
  logic [31:0] diff;
  logic [23:0] spd_lim;
  logic [23:0] spd_act;
  logic [2:0]  sw_baud;
  logic [IRQ_W-1:0] ev;

  // ---------------------------------------------------------------
  // Combinational helpers
  // ---------------------------------------------------------------
  always_comb
  begin
    req     = wb_cyc_i & wb_stb_i & ~r.ack & ~r.err;
    wr      = req & wb_we_i & (wb_sel_i == 4'hF);
    cmd     = r.ctrl[CW_RUN_UP] | r.ctrl[CW_RUN_DN];
    // Scale actual speed by 100 and target speed by the stall percentage so no divider is needed
    spd_lim = 24'(r.stall_pct) * 24'(motion_i.target_speed);
    spd_act = 24'(motion_i.actual_speed) * PCT_FULL;
    slow    = spd_act < spd_lim;
    diff    = (motion_i.target_pos > motion_i.actual_pos)
            ? motion_i.target_pos - motion_i.actual_pos
            : motion_i.actual_pos - motion_i.target_pos;
    case (r.sw_q3[1:0])
      2'h0:    sw_baud = BAUD_125;
      2'h1:    sw_baud = BAUD_250;
      default: sw_baud = BAUD_500;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    next_r     = r;
    ev         = '0;
    next_r.ack = 1'b0;
    next_r.err = 1'b0;

    // Three-stage switch sampler; only stage 2 may read the metastable stage 1
    next_r.sw_q1 = {1'b0, baud_switch_i};
    next_r.sw_q2 = r.sw_q1;
    next_r.sw_q3 = r.sw_q2;

    // 100 us tick divider
    next_r.pre_cnt = r.pre_cnt + 1'b1;
    next_r.tick    = 1'b0;
    if (r.pre_cnt == TICK_W'(TICK_CYC - 1))
    begin
      next_r.pre_cnt = '0;
      next_r.tick    = 1'b1;
    end

    // Run sequencer
    case (r.st)
      ST_IDLE:
      begin
        if (cmd)
        begin
          next_r.dir_up  = r.ctrl[CW_RUN_UP];
          next_r.tcnt    = '0;
          next_r.pos_err = 1'b0;
          ev[EV_START]   = 1'b1;
          if (brake_kind_i == BRK_NONE)
            next_r.st = ST_RUN;
          else
            next_r.st = ST_PRE;
        end
      end
      ST_PRE:
      begin
        if (r.tick)
          next_r.tcnt = r.tcnt + 1'b1;
        if (brake_kind_i == BRK_SNAP && r.tcnt >= 20'(r.pre_dly) * 20'(TICKS_PER_MS))
        begin
          next_r.brake_open = 1'b1;
          next_r.bcnt       = '0;
          next_r.st         = ST_BACKOFF;
        end
        else if (brake_kind_i != BRK_SNAP && r.tcnt >= 20'(r.hold_dly) * 20'(TICKS_PER_MS))
          next_r.st = ST_RUN;
      end
      ST_BACKOFF:
      begin
        if (motion_i.backoff_step)
          next_r.bcnt = r.bcnt + 1'b1;
        // Leave on the step that reaches the count, else the core takes one too many
        if (next_r.bcnt >= r.backoff)
        begin
          next_r.scnt = '0;
          next_r.st   = ST_RUN;
        end
      end
      ST_RUN:
      begin
        next_r.moving = 1'b1;
        if (slow && r.tick)
          next_r.scnt = r.scnt + 1'b1;
        else if (!slow)
          next_r.scnt = '0;
        if (diff > 32'(r.drag) && !r.drag_err)
        begin
          next_r.drag_err = 1'b1;
          ev[EV_DRAG]     = 1'b1;
        end
        if (r.scnt > 20'(r.stall_ms) * 20'(TICKS_PER_MS) || motion_i.run_done || r.ctrl[CW_STOP])
        begin
          if (r.scnt > 20'(r.stall_ms) * 20'(TICKS_PER_MS))
          begin
            next_r.pos_err  = 1'b1;
            ev[EV_STALL]    = 1'b1;
          end
          next_r.moving = 1'b0;
          next_r.tcnt   = '0;
          next_r.ctrl[CW_RUN_UP] = 1'b0;
          next_r.ctrl[CW_RUN_DN] = 1'b0;
          next_r.ctrl[CW_STOP]   = 1'b0;
          ev[EV_END]    = 1'b1;
          if (brake_kind_i == BRK_SNAP)
            next_r.st = ST_CLOSE;
          else
          begin
            next_r.brake_open = 1'b0;
            next_r.st         = ST_IDLE;
          end
        end
      end
      ST_CLOSE:
      begin
        if (r.tick)
          next_r.tcnt = r.tcnt + 1'b1;
        if (cmd)
        begin
          // Brake still open, go straight to motion
          next_r.dir_up  = r.ctrl[CW_RUN_UP];
          next_r.scnt    = '0;
          next_r.pos_err = 1'b0;
          ev[EV_START]   = 1'b1;
          next_r.st      = ST_RUN;
        end
        else if (r.tcnt >= 20'(r.close_dly) * 20'(TICKS_PER_MS))
        begin
          next_r.brake_open = 1'b0;
          next_r.st         = ST_IDLE;
        end
      end
      default: next_r.st = ST_IDLE;
    endcase
    if (r.st == ST_PRE && brake_kind_i != BRK_SNAP && next_r.st == ST_RUN)
    begin
      next_r.brake_open = 1'b1;
      next_r.scnt       = '0;
    end
    // A stale stall count from an aborted run must not end the next one
    if (r.st != ST_RUN && next_r.st == ST_RUN)
    begin
      next_r.drag_err = 1'b0;
      next_r.scnt     = '0;
    end

    // Bit rate: switch unless bus has overridden it
    // Switch value only counts once stages 2 and 3 agree
    if (!r.baud_bus && r.sw_q2 == r.sw_q3)
      next_r.baud_code = sw_baud;

    // Register writes
    if (wr)
    begin
      case (wb_adr_i)
        REG_CTRL:      next_r.ctrl      = wb_dat_i[15:0];
        REG_PRE_DLY:   next_r.pre_dly   = wb_dat_i[15:0];
        REG_CLOSE_DLY: next_r.close_dly = wb_dat_i[15:0];
        REG_HOLD_DLY:  next_r.hold_dly  = wb_dat_i[15:0];
        REG_BACKOFF:   next_r.backoff   = wb_dat_i[15:0];
        REG_STALL_PCT: next_r.stall_pct = wb_dat_i[7:0];
        REG_STALL_MS:  next_r.stall_ms  = wb_dat_i[15:0];
        REG_DRAG:      next_r.drag      = wb_dat_i[15:0];
        REG_IRQ_MASK:  next_r.irq_mask  = wb_dat_i[IRQ_W-1:0];
        REG_BAUD:
        begin
          // Bus may pick any of the five rates
          if (wb_dat_i[2:0] <= BAUD_1000)
          begin
            next_r.baud_bus  = 1'b1;
            next_r.baud_code = wb_dat_i[2:0];
          end
        end
        default: ;
      endcase
    end

    // Sticky events, a new event beats a write-one clear
    next_r.irq_stat = r.irq_stat;
    if (wr && wb_adr_i == REG_IRQ_STAT)
      next_r.irq_stat = r.irq_stat & ~wb_dat_i[IRQ_W-1:0];
    next_r.irq_stat = next_r.irq_stat | ev;

    // Read data and answer
    if (req)
    begin
      next_r.ack   = 1'b1;
      next_r.rdata = '0;
      case (wb_adr_i)
        REG_CTRL:      next_r.rdata = {16'h0000, r.ctrl};
        REG_STATUS:    next_r.rdata = {21'h00_0000, r.pos_err, 1'b0, r.brake_open,
                                       r.drag_err, r.moving, 6'h00};
        REG_PRE_DLY:   next_r.rdata = {16'h0000, r.pre_dly};
        REG_CLOSE_DLY: next_r.rdata = {16'h0000, r.close_dly};
        REG_HOLD_DLY:  next_r.rdata = {16'h0000, r.hold_dly};
        REG_BACKOFF:   next_r.rdata = {16'h0000, r.backoff};
        REG_STALL_PCT: next_r.rdata = {24'h00_0000, r.stall_pct};
        REG_STALL_MS:  next_r.rdata = {16'h0000, r.stall_ms};
        REG_DRAG:      next_r.rdata = {16'h0000, r.drag};
        REG_IRQ_STAT:  next_r.rdata = {28'h000_0000, r.irq_stat};
        REG_IRQ_MASK:  next_r.rdata = {28'h000_0000, r.irq_mask};
        REG_BAUD:      next_r.rdata = {28'h000_0000, r.baud_bus, r.baud_code};
        default:
        begin
          // Unmapped address answers with an error
          next_r.ack = 1'b0;
          next_r.err = 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register stage
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r           <= '0;
      r.st        <= ST_IDLE;
      r.pre_dly   <= PRE_DLY_MS;
      r.close_dly <= CLOSE_DLY_MS;
      r.hold_dly  <= HOLD_DLY_MS;
      r.backoff   <= BACKOFF_INC;
      r.stall_pct <= STALL_PCT;
      r.stall_ms  <= STALL_MS;
      r.drag      <= DRAG_LIMIT;
      r.baud_code <= BAUD_125;
    end
    else
      r <= next_r;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign wb_dat_o            = r.rdata;
  assign wb_ack_o            = r.ack;
  assign wb_err_o            = r.err;
  assign drive_o.motor_en    = (r.st == ST_RUN) | (r.st == ST_BACKOFF);
  assign drive_o.dir_up      = (r.st == ST_BACKOFF) ? ~r.dir_up : r.dir_up;
  assign drive_o.backoff     = (r.st == ST_BACKOFF);
  assign drive_o.brake_open  = r.brake_open;
  assign baud_sel_o          = r.baud_code;
  assign irq_o               = |(r.irq_stat & r.irq_mask);

endmodule

// *** tb/brsq_properties.sv ***
`timescale 1ns/1ns
module brsq_properties
  import brsq_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         rst_i,
  input wire logic         wb_cyc_i,
  input wire logic         wb_stb_i,
  input wire logic         wb_ack_o,
  input wire logic         wb_err_o,
  input wire brsq_brake_t  brake_kind_i,
  input wire brsq_motion_t motion_i,
  input wire brsq_drive_t  drive_o,
  input wire logic [2:0]   baud_sel_o,
  input wire logic         irq_o
);
  // ------------------------------------------------
  // Bus answer shape and quiet outputs after reset
  // ------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held past one cycle");
  property p_ack_cause; wb_ack_o || wb_err_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause)
    else $error("answer without request");
  property p_one_answer; !(wb_ack_o && wb_err_o); endproperty
  a_one_answer: assert property (p_one_answer)
    else $error("ack and err together");
  property p_rst_quiet; $past(rst_i) |-> drive_o == '0 && !irq_o && !wb_ack_o; endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active after reset");
  // ------------------------------------------------
  // Brake sequencing and bit rate code range
  // ------------------------------------------------
  sequence s_hold_end;
    brake_kind_i == BRK_HOLD && drive_o.motor_en && motion_i.run_done;
  endsequence
  sequence s_snap_end;
    brake_kind_i == BRK_SNAP && drive_o.motor_en && !drive_o.backoff && motion_i.run_done;
  endsequence
  property p_bo_open; drive_o.backoff |-> drive_o.motor_en && drive_o.brake_open; endproperty
  a_bo_open: assert property (p_bo_open)
    else $error("backoff with brake shut");
  property p_run_open; drive_o.motor_en && brake_kind_i != BRK_NONE |-> drive_o.brake_open; endproperty
  a_run_open: assert property (p_run_open)
    else $error("motion against closed brake");
  property p_hold_rel; s_hold_end |-> ##[1:3] !drive_o.brake_open; endproperty
  a_hold_rel: assert property (p_hold_rel)
    else $error("holding brake not released");
  // Close delay is never zero in the runs that reach this
  property p_snap_keep; s_snap_end |=> drive_o.brake_open [*2]; endproperty
  a_snap_keep: assert property (p_snap_keep)
    else $error("snap brake closed at once");
  property p_baud_code; baud_sel_o <= BAUD_1000; endproperty
  a_baud_code: assert property (p_baud_code)
    else $error("bit rate code out of range");
endmodule

// *** tb/brsq_core_model.sv ***
`timescale 1ns/1ns
module brsq_core_model
  import brsq_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        slow_i,
  input  wire brsq_drive_t drive_i,
  output brsq_motion_t     motion_o
);
  logic [7:0]  rcnt;
  logic        step;
  logic        done;
  logic [15:0] act;
  // Step pulse every other cycle; run ends 40 cycles in, never when stalled
  always_ff @(posedge clk_i)
  begin
    step <= !rst_i && drive_i.backoff && !step;
    done <= !rst_i && drive_i.motor_en && !drive_i.backoff && rcnt == 8'h27 && !slow_i;
    rcnt <= (rst_i || !drive_i.motor_en || drive_i.backoff) ? 8'h00 : rcnt + 8'h01;
  end
  // Slow speed is 10% of target, below any stall threshold above 10%
  assign act = !drive_i.motor_en ? 16'h0000 : slow_i ? 16'h0064 : 16'h03E8;
  // Target pulls ahead 16 increments a cycle, so a full run trips the default drag limit
  assign motion_o = '{16'h03E8, act, {20'h0_0000, rcnt, 4'h0}, 32'h0000_0000, done, step};
endmodule

// *** tb/test_brsq_top.sv ***
`timescale 1ns/1ns
module test_brsq_top
  import brsq_pkg::*;
;
  logic         clk_i = 0, rst_i = 1, wb_we_i = 0, wb_cyc_i = 0, wb_stb_i = 0, slow = 0;
  logic [7:0]   wb_adr_i = 8'h00;
  logic [31:0]  wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
  logic [3:0]   wb_sel_i = 4'hF;
  logic         wb_ack_o, wb_err_o, irq_o, er, seen, bo_dir;
  logic [1:0]   baud_switch_i = 2'h0;
  logic [2:0]   baud_sel_o;
  brsq_brake_t  brake_kind_i = BRK_NONE;
  brsq_motion_t motion_i;
  brsq_drive_t  drive_o;
  int           failures = 0, n_checks = 0, cyc = 0, bo_cnt = 0, seed = 62416, nb;
  logic [7:0]   ra [7] = '{REG_PRE_DLY, REG_CLOSE_DLY, REG_BACKOFF, REG_STALL_PCT, REG_STALL_MS, REG_DRAG,
                           REG_HOLD_DLY};
  logic [31:0]  re [7] = '{PRE_DLY_MS, CLOSE_DLY_MS, BACKOFF_INC, STALL_PCT, STALL_MS, DRAG_LIMIT, HOLD_DLY_MS};

  brsq_top brsq_top_i (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i,
    .wb_dat_o, .wb_ack_o, .wb_err_o, .brake_kind_i, .baud_switch_i, .motion_i, .drive_o, .baud_sel_o, .irq_o);
  brsq_core_model brsq_core_model_i (.clk_i, .rst_i, .slow_i(slow), .drive_i(drive_o), .motion_o(motion_i));

  // ------------------------------------------------
  // Clock, watchdog and backoff monitor
  // ------------------------------------------------
  initial forever #4 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (motion_i.backoff_step === 1'b1) bo_cnt <= bo_cnt + 1;
    if (drive_o.backoff === 1'b1) bo_dir <= drive_o.dir_up;
    if (cyc == 100000)
    begin
      failures = failures + 1;
      end_sim;
    end
  end

  // ------------------------------------------------
  // Tasks and expectations
  // ------------------------------------------------
  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Classic cycle: held until ack or err is sampled, then one idle cycle
  task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    wb_adr_i <= a;
    wb_we_i <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    @(posedge clk_i);
  endtask
  // Master polls the status word; the watchdog bounds the wait
  task wait_st(input int b, input logic v);
    do wb(REG_STATUS, 0, 0); while (rd[b] !== v);
  endtask
  task rst;
    rst_i <= 1;
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
  endtask
  function logic [2:0] baud_exp(input logic [1:0] s);
    return s == 2'h0 ? BAUD_125 : s == 2'h1 ? BAUD_250 : BAUD_500;
  endfunction
  task end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ------------------------------------------------
  // Scenarios
  // ------------------------------------------------
  initial
  begin
    rst;
    for (int i = 0; i < 7; i++)
    begin
      wb(ra[i], 0, 0);
      chk("reset value", rd, re[i]);
    end
    wb(8'h40, 1, 32'h0000_0001);
    chk("unmapped err", er, 1);
    for (int s = 0; s < 3; s++)
    begin
      baud_switch_i <= s[1:0];
      repeat (8) @(posedge clk_i);
      chk("switch baud", baud_sel_o, baud_exp(s[1:0]));
    end
    for (int c = 0; c < 6; c++)
    begin
      wb(REG_BAUD, 1, c);
      chk("bus baud", baud_sel_o, c > 4 ? 4 : c);
    end
    $display("test regs and baud done");
    wb(REG_STALL_PCT, 1, 32'h0000_003C);
    wb(REG_STALL_MS, 1, 32'h0000_0064);
    wb(REG_STALL_MS, 0, 0);
    chk("stall time", rd, 32'h0000_0064);
    wb(REG_STALL_MS, 1, 0);
    slow <= 1;
    wb(REG_CTRL, 1, 32'h0000_0001);
    wait_st(SW_MOVING, 1);
    wait_st(SW_POS_ERR, 1);
    chk("moving after stall", rd[SW_MOVING], 0);
    chk("irq masked", irq_o, 0);
    wb(REG_IRQ_MASK, 1, 32'h0000_000F);
    chk("irq raised", irq_o, 1);
    wb(REG_IRQ_STAT, 0, 0);
    chk("stall event", rd[EV_STALL], 1);
    wb(REG_IRQ_STAT, 1, 32'h0000_000F);
    chk("irq cleared", irq_o, 0);
    slow <= 0;
    wb(REG_CTRL, 1, 32'h0000_0002);
    wait_st(SW_MOVING, 1);
    wait_st(SW_MOVING, 0);
    chk("drag flag", rd[SW_DRAG], 1);
    $display("test stall done");
    // Random backoff count, then a second run inside the close delay
    nb = ($random(seed) & 7) + 1;
    brake_kind_i <= BRK_SNAP;
    wb(REG_PRE_DLY, 1, 0);
    wb(REG_CLOSE_DLY, 1, 32'h0000_0001);
    wb(REG_BACKOFF, 1, nb);
    wb(REG_DRAG, 1, 32'h0000_FFFF);
    bo_cnt <= 0;
    wb(REG_CTRL, 1, 32'h0000_0001);
    wait_st(SW_MOVING, 1);
    chk("backoff count", bo_cnt, nb);
    chk("backoff dir", bo_dir, 0);
    wait_st(SW_MOVING, 0);
    chk("drag quiet", rd[SW_DRAG], 0);
    chk("brake kept open", drive_o.brake_open, 1);
    bo_cnt <= 0;
    wb(REG_CTRL, 1, 32'h0000_0002);
    wait_st(SW_MOVING, 1);
    chk("no second release", bo_cnt, 0);
    rst;
    brake_kind_i <= BRK_HOLD;
    wb(REG_HOLD_DLY, 1, 0);
    wb(REG_CTRL, 1, 32'h0000_0001);
    wait_st(SW_MOVING, 1);
    wait_st(SW_MOVING, 0);
    chk("hold brake released", drive_o.brake_open, 0);
    // Stop bit ends a run that the core would never finish by itself
    slow <= 1;
    wb(REG_CTRL, 1, 32'h0000_0001);
    wait_st(SW_MOVING, 1);
    wb(REG_CTRL, 1, 32'h0000_0005);
    wait_st(SW_MOVING, 0);
    chk("stop no error", rd[SW_POS_ERR], 0);
    chk("hold brake after stop", drive_o.brake_open, 0);
    slow <= 0;
    $display("test brakes done");
    // 1 ms start delay; only the first 3000 cycles are watched
    for (int k = 0; k < 2; k++)
    begin
      rst;
      brake_kind_i <= k ? BRK_HOLD : BRK_SNAP;
      wb(k ? REG_HOLD_DLY : REG_PRE_DLY, 1, 32'h0000_0001);
      wb(REG_CTRL, 1, 32'h0000_0001);
      seen = 0;
      repeat (3000) @(posedge clk_i) seen |= drive_o.motor_en;
      chk("start delayed", seen, 0);
    end
    $display("test start delay done");
    end_sim;
  end
endmodule

bind brsq_top brsq_properties brsq_properties_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o,
  .brake_kind_i, .motion_i, .drive_o, .baud_sel_o, .irq_o);
